/* File: src/irq_consts.vh */
// constants for the interrupt arbiter and standby controller
// assumes a 100 MHz system clock and a word-wide register port
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH

// register indexes
`define REG_LEVEL_LO    4'h0
`define REG_LEVEL_HI    4'h1
`define REG_EXTMODE_LO  4'h2
`define REG_EXTMODE_HI  4'h3
`define REG_PORT0_EN    4'h4
`define REG_EXTFLAG     4'h5
`define REG_STANDBY     4'h6
`define REG_PENDING     4'h7
`define REG_STATUS      4'h8

// reset values
`define LEVEL_RST       2'h0
`define EXTMODE_RST     3'h0

// priority levels, zero masks the vector
`define LVL_OFF         2'h0
`define LVL_LOW         2'h1
`define LVL_HIGH        2'h2
`define LVL_TOP         2'h3

// external pin trigger modes
`define TRIG_OFF        3'h0
`define TRIG_HIGH       3'h1
`define TRIG_LOW        3'h2
`define TRIG_RISE       3'h3
`define TRIG_FALL       3'h4
`define TRIG_BOTH       3'h5

// standby commands in bits 1:0, crystal enable in bit 4
`define SBY_PAUSE       2'h1
`define SBY_STOP        2'h2
`define SBY_KEEP        2'h3
`define SBY_XTAL_BIT    4

// vector table
`define VEC_BASE        20'h08000
`define VEC_STEP        20'h00004
`define VEC_LAST        20'h0803C
`define NUM_VEC         14
`define NUM_PERIPH      50
`define NUM_SRC         61

// stack frame sizes in bytes
`define FRAME_IRQ       3'h6
`define FRAME_CALL_PSW  3'h6
`define FRAME_CALL      3'h4

// oscillator restart time after wake
`define CLK_PERIOD_NS   10
`define OSC_RESTART_NS  1000
`define OSC_RESTART_CYC \
   ((`OSC_RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: src/irq_priority_and_standby_wake.v */
// interrupt arbiter with three nested levels and standby wake logic
// assumes peripheral requests are levels on mclk_i; pins are async
`timescale 1ns/10ps
`include "irq_consts.vh"

module irq_priority_and_standby_wake #(
   parameter RESTART_CYC = `OSC_RESTART_CYC
) (
   // clock and reset
   input  wire        mclk_i,
   input  wire        rst_i,
   // register port
   input  wire [3:0]  addr_i,
   input  wire [15:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [15:0] rdata_o,
   // request sources
   input  wire [49:0] periph_irq_i,
   input  wire [7:0]  ext_irq_pin_i,
   input  wire [5:0]  port0_pin_i,
   input  wire        reset_pin_n_i,
   // processor core
   output reg         irq_req_o,
   output reg  [19:0] irq_vec_o,
   output reg  [1:0]  irq_level_o,
   input  wire        irq_ack_i,
   input  wire        irq_ret_i,
   input  wire        call_psw_i,
   input  wire        call_plain_i,
   output reg         push_o,
   output reg  [2:0]  push_bytes_o,
   // standby control
   output reg         cpu_halt_o,
   output reg         periph_stop_o,
   output reg         ceramic_main_clock_en_o,
   output reg         internal_oscillator_clock_en_o,
   output reg         low_speed_crystal_clock_en_o
);

   localparam ST_RUN   = 5'h01;
   localparam ST_PAUSE = 5'h02;
   localparam ST_STOP  = 5'h04;
   localparam ST_KEEP  = 5'h08;
   localparam ST_WAKE  = 5'h10;

   reg  [15:0] level_lo;
   reg  [11:0] level_hi;
   reg  [11:0] extmode_lo;
   reg  [11:0] extmode_hi;
   reg  [5:0]  port0_en;
   reg  [7:0]  ext_flag;
   reg         xtal_ctl;
   reg         xtal_hold;
   reg  [7:0]  ext_s1;
   reg  [7:0]  ext_s2;
   reg  [7:0]  ext_prev;
   reg  [5:0]  p0_s1;
   reg  [5:0]  p0_s2;
   reg         rstpin_s1;
   reg         rstpin_s2;
   reg  [3:1]  in_service;
   reg  [4:0]  state;
   reg  [4:0]  next_state;
   reg  [15:0] restart_cnt;
   reg  [7:0]  next_ext_flag;
   reg  [7:0]  ext_src;
   reg  [2:0]  mode;
   reg  [1:0]  cur_level;
   reg  [1:0]  best_level;
   reg  [3:0]  best_vec;
   reg  [1:0]  vlevel;
   reg  [13:0] pending;
   reg         next_req;
   reg         stop_wake;
   reg         keep_wake;
   wire [2:0]  port0_src;
   wire [27:0] levels;
   wire [23:0] extmodes;
   integer     i;
   integer     j;

   assign levels   = {level_hi, level_lo};
   assign extmodes = {extmode_hi, extmode_lo};

   // vector address from vector number, skipping the two holes
   function [19:0] vec_addr;
      input [3:0] v;
      reg   [3:0] slot;
      begin
         if (v < 4'h4) begin
            slot = v;
         end else if (v < 4'hA) begin
            slot = v + 4'h1;
         end else begin
            slot = v + 4'h2;
         end
         vec_addr = `VEC_BASE + {14'h0000, slot, 2'h0};
      end
   endfunction

   // pin synchronisers
   always @(posedge mclk_i) begin
      if (rst_i) begin
         ext_s1    <= 8'h00;
         ext_s2    <= 8'h00;
         ext_prev  <= 8'h00;
         p0_s1     <= 6'h00;
         p0_s2     <= 6'h00;
         rstpin_s1 <= 1'b1;
         rstpin_s2 <= 1'b1;
      end else begin
         ext_s1    <= ext_irq_pin_i;
         ext_s2    <= ext_s1;
         ext_prev  <= ext_s2;
         p0_s1     <= port0_pin_i;
         p0_s2     <= p0_s1;
         rstpin_s1 <= reset_pin_n_i;
         rstpin_s2 <= rstpin_s1;
      end
   end

   // external pin trigger detection
   always @* begin
      next_ext_flag = ext_flag;
      ext_src = 8'h00;
      mode = `TRIG_OFF;
      for (i = 0; i < 8; i = i + 1) begin
         mode = extmodes[i*3 +: 3];
         if (wr_i && addr_i == `REG_EXTFLAG && wdata_i[i]) begin
            next_ext_flag[i] = 1'b0;
         end
         if ((mode == `TRIG_RISE || mode == `TRIG_BOTH) &&
             ext_s2[i] && !ext_prev[i]) begin
            next_ext_flag[i] = 1'b1;
         end
         if ((mode == `TRIG_FALL || mode == `TRIG_BOTH) &&
             !ext_s2[i] && ext_prev[i]) begin
            next_ext_flag[i] = 1'b1;
         end
         if (mode == `TRIG_HIGH) begin
            ext_src[i] = ext_s2[i];
         end else if (mode == `TRIG_LOW) begin
            ext_src[i] = !ext_s2[i];
         end else begin
            ext_src[i] = ext_flag[i];
         end
      end
   end

   // port 0 pins pair onto three sources
   assign port0_src[0] = |(p0_s2[1:0] & port0_en[1:0]);
   assign port0_src[1] = |(p0_s2[3:2] & port0_en[3:2]);
   assign port0_src[2] = |(p0_s2[5:4] & port0_en[5:4]);

   // merge of all sources onto the vectors
   always @* begin
      pending[0]  = periph_irq_i[0];
      pending[1]  = |periph_irq_i[2:1];
      pending[2]  = |periph_irq_i[4:3];
      pending[3]  = ext_src[0];
      pending[4]  = ext_src[1];
      pending[5]  = ext_src[2] | (|periph_irq_i[10:5]);
      pending[6]  = ext_src[3] | (|periph_irq_i[16:11]);
      pending[7]  = ext_src[4] | (|periph_irq_i[22:17]);
      pending[8]  = ext_src[5] | (|periph_irq_i[25:23]);
      pending[9]  = |periph_irq_i[27:26];
      pending[10] = |periph_irq_i[31:28];
      pending[11] = ext_src[6] | (|periph_irq_i[36:32]);
      pending[12] = ext_src[7] | (|periph_irq_i[39:37]);
      pending[13] = (|port0_src) | (|periph_irq_i[49:40]);
   end

   // arbitration
   always @* begin
      if (in_service[3]) begin
         cur_level = `LVL_TOP;
      end else if (in_service[2]) begin
         cur_level = `LVL_HIGH;
      end else if (in_service[1]) begin
         cur_level = `LVL_LOW;
      end else begin
         cur_level = `LVL_OFF;
      end
      best_level = `LVL_OFF;
      best_vec   = 4'h0;
      vlevel     = `LVL_OFF;
      for (j = `NUM_VEC - 1; j >= 0; j = j - 1) begin
         vlevel = levels[j*2 +: 2];
         if (pending[j] && vlevel != `LVL_OFF &&
             vlevel >= best_level) begin
            best_level = vlevel;
            best_vec   = j[3:0];
         end
      end
      next_req = (best_level > cur_level) && !irq_ack_i &&
                 (state == ST_RUN || state == ST_PAUSE);
   end

   // wake conditions
   always @* begin
      stop_wake = !rstpin_s2 ||
                  (|ext_src[2:0]) || (|ext_src[7:4]) ||
                  (|port0_src) || (|periph_irq_i[47:40]) ||
                  (|periph_irq_i[39:37]) ||
                  (|periph_irq_i[25:24]) ||
                  (|periph_irq_i[31:30]) ||
                  (|periph_irq_i[10:7]) ||
                  (|periph_irq_i[36:33]);
      keep_wake = stop_wake ||
                  (|periph_irq_i[2:1]) ||
                  (|periph_irq_i[22:19]) ||
                  periph_irq_i[48];
   end

   // standby state machine
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (wr_i && addr_i == `REG_STANDBY) begin
               if (wdata_i[1:0] == `SBY_PAUSE) begin
                  next_state = ST_PAUSE;
               end else if (wdata_i[1:0] == `SBY_STOP) begin
                  next_state = ST_STOP;
               end else if (wdata_i[1:0] == `SBY_KEEP) begin
                  next_state = ST_KEEP;
               end
            end
         end
         ST_PAUSE: begin
            if (next_req) begin
               next_state = ST_RUN;
            end
         end
         ST_STOP: begin
            if (stop_wake) begin
               next_state = ST_WAKE;
            end
         end
         ST_KEEP: begin
            if (keep_wake) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (restart_cnt == 16'h0000) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         state       <= ST_RUN;
         restart_cnt <= 16'h0000;
         xtal_hold   <= 1'b0;
         cpu_halt_o                     <= 1'b0;
         periph_stop_o                  <= 1'b0;
         ceramic_main_clock_en_o        <= 1'b1;
         internal_oscillator_clock_en_o <= 1'b1;
         low_speed_crystal_clock_en_o   <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state == ST_WAKE && state != ST_WAKE) begin
            restart_cnt <= RESTART_CYC[15:0] - 16'h0001;
         end else if (restart_cnt != 16'h0000) begin
            restart_cnt <= restart_cnt - 16'h0001;
         end
         if (next_state == ST_KEEP && state != ST_KEEP) begin
            xtal_hold <= xtal_ctl;
         end
         cpu_halt_o    <= (next_state != ST_RUN);
         periph_stop_o <= (next_state == ST_STOP) ||
                          (next_state == ST_KEEP) ||
                          (next_state == ST_WAKE);
         ceramic_main_clock_en_o <= (next_state != ST_STOP) &&
                                    (next_state != ST_KEEP);
         internal_oscillator_clock_en_o <= (next_state != ST_STOP) &&
                                           (next_state != ST_KEEP);
         if (next_state == ST_STOP) begin
            low_speed_crystal_clock_en_o <= 1'b0;
         end else if (next_state == ST_KEEP) begin
            low_speed_crystal_clock_en_o <=
               (state == ST_KEEP) ? xtal_hold : xtal_ctl;
         end else begin
            low_speed_crystal_clock_en_o <= xtal_ctl;
         end
      end
   end

   // nesting, vector output and stack frames
   always @(posedge mclk_i) begin
      if (rst_i) begin
         in_service   <= 3'h0;
         irq_req_o    <= 1'b0;
         irq_vec_o    <= `VEC_BASE;
         irq_level_o  <= `LVL_OFF;
         push_o       <= 1'b0;
         push_bytes_o <= 3'h0;
      end else begin
         if (irq_ack_i && irq_req_o) begin
            in_service[irq_level_o] <= 1'b1;
         end else if (irq_ret_i) begin
            if (in_service[3]) begin
               in_service[3] <= 1'b0;
            end else if (in_service[2]) begin
               in_service[2] <= 1'b0;
            end else begin
               in_service[1] <= 1'b0;
            end
         end
         irq_req_o <= next_req && (next_state == ST_RUN);
         if (next_req) begin
            irq_vec_o   <= vec_addr(best_vec);
            irq_level_o <= best_level;
         end
         push_o <= (irq_ack_i && irq_req_o) || call_psw_i ||
                   call_plain_i;
         if (irq_ack_i && irq_req_o) begin
            push_bytes_o <= `FRAME_IRQ;
         end else if (call_psw_i) begin
            push_bytes_o <= `FRAME_CALL_PSW;
         end else if (call_plain_i) begin
            push_bytes_o <= `FRAME_CALL;
         end else begin
            push_bytes_o <= 3'h0;
         end
      end
   end

   // register writes
   always @(posedge mclk_i) begin
      if (rst_i) begin
         level_lo   <= {8{`LEVEL_RST}};
         level_hi   <= {6{`LEVEL_RST}};
         extmode_lo <= {4{`EXTMODE_RST}};
         extmode_hi <= {4{`EXTMODE_RST}};
         port0_en   <= 6'h00;
         ext_flag   <= 8'h00;
         xtal_ctl   <= 1'b0;
      end else begin
         ext_flag <= next_ext_flag;
         if (wr_i) begin
            if (addr_i == `REG_LEVEL_LO) begin
               level_lo <= wdata_i;
            end else if (addr_i == `REG_LEVEL_HI) begin
               level_hi <= wdata_i[11:0];
            end else if (addr_i == `REG_EXTMODE_LO) begin
               extmode_lo <= wdata_i[11:0];
            end else if (addr_i == `REG_EXTMODE_HI) begin
               extmode_hi <= wdata_i[11:0];
            end else if (addr_i == `REG_PORT0_EN) begin
               port0_en <= wdata_i[5:0];
            end else if (addr_i == `REG_STANDBY) begin
               xtal_ctl <= wdata_i[`SBY_XTAL_BIT];
            end
         end
      end
   end

   // register reads, data one cycle after the strobe
   always @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         if (addr_i == `REG_LEVEL_LO) begin
            rdata_o <= level_lo;
         end else if (addr_i == `REG_LEVEL_HI) begin
            rdata_o <= {4'h0, level_hi};
         end else if (addr_i == `REG_EXTMODE_LO) begin
            rdata_o <= {4'h0, extmode_lo};
         end else if (addr_i == `REG_EXTMODE_HI) begin
            rdata_o <= {4'h0, extmode_hi};
         end else if (addr_i == `REG_PORT0_EN) begin
            rdata_o <= {10'h000, port0_en};
         end else if (addr_i == `REG_EXTFLAG) begin
            rdata_o <= {8'h00, ext_flag};
         end else if (addr_i == `REG_STANDBY) begin
            rdata_o <= {11'h000, xtal_ctl, 4'h0};
         end else if (addr_i == `REG_PENDING) begin
            rdata_o <= {2'h0, pending};
         end else if (addr_i == `REG_STATUS) begin
            rdata_o <= {3'h0, state, 3'h0, in_service, 2'h0};
         end else begin
            rdata_o <= 16'h0000;
         end
      end else begin
         rdata_o <= 16'h0000;
      end
   end

endmodule

/* File: tb/irq_wake_props.sv */
// port checks for the interrupt arbiter and standby logic
// assumes one clock domain and rst_i synchronous active high
`timescale 1ns/10ps
module irq_wake_props #(
   parameter RESTART_CYC = 3
) (
   // clock and reset
   input wire        mclk_i,
   input wire        rst_i,
   // core side
   input wire        irq_req_o,
   input wire [19:0] irq_vec_o,
   input wire [1:0]  irq_level_o,
   input wire        irq_ack_i,
   input wire        irq_ret_i,
   input wire        call_psw_i,
   input wire        call_plain_i,
   input wire        push_o,
   input wire [2:0]  push_bytes_o,
   // standby
   input wire        cpu_halt_o,
   input wire        periph_stop_o,
   input wire        ceramic_main_clock_en_o,
   input wire        internal_oscillator_clock_en_o,
   input wire        low_speed_crystal_clock_en_o
);
   reg  [3:1] in_svc;
   reg  [7:0] wk_cnt;
   reg        armed;
   wire       cer = ceramic_main_clock_en_o;
   wire [1:0] top = in_svc[3] ? 2'h3 : in_svc[2] ? 2'h2 : {1'b0, in_svc[1]};
   // shadow of the in-service levels and the wake restart count
   always @(posedge mclk_i) begin
      if (rst_i) begin
         in_svc <= 3'h0;
         armed  <= 1'b0;
         wk_cnt <= 8'h00;
      end else begin
         if (irq_req_o && irq_ack_i)
            in_svc[irq_level_o] <= 1'b1;
         else if (irq_ret_i)
            in_svc <= in_svc[3] ? {1'b0, in_svc[2:1]} :
                      in_svc[2] ? {2'h0, in_svc[1]} : 3'h0;
         armed  <= !cer | (armed & cpu_halt_o);
         wk_cnt <= !cer ? 8'h00 : wk_cnt + 8'h01;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_vec_map;
      irq_req_o |-> irq_vec_o[1:0] == 2'h0 && irq_vec_o >= 20'h08000 &&
         irq_vec_o <= 20'h0803C && irq_vec_o != 20'h08010 &&
         irq_vec_o != 20'h0802C;
   endproperty
   a_vec_map: assert property (p_vec_map) else $error("bad vector");
   property p_lvl_above;
      irq_req_o |-> irq_level_o != 2'h0 && irq_level_o > top;
   endproperty
   a_lvl_above: assert property (p_lvl_above) else $error("level low");
   property p_ack_drop;
      irq_req_o && irq_ack_i |=> !irq_req_o;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("grant stays");
   property p_ack_push;
      irq_req_o && irq_ack_i |=> push_o && push_bytes_o == 3'h6;
   endproperty
   a_ack_push: assert property (p_ack_push) else $error("entry push");
   property p_call_push;
      call_plain_i && !call_psw_i |=> push_o && push_bytes_o == 3'h4;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call push");
   property p_grant_runs;
      $rose(irq_req_o) |-> !cpu_halt_o && !periph_stop_o;
   endproperty
   a_grant_runs: assert property (p_grant_runs) else $error("halted");
   property p_stop_entry;
      $rose(periph_stop_o) |-> cpu_halt_o && !cer &&
         !internal_oscillator_clock_en_o;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("osc on");
   property p_keep_xtal;
      !cer && !$past(cer) |-> $stable(low_speed_crystal_clock_en_o);
   endproperty
   a_keep_xtal: assert property (p_keep_xtal) else $error("xtal moved");
   property p_no_grant_off;
      !cer |-> !irq_req_o;
   endproperty
   a_no_grant_off: assert property (p_no_grant_off) else $error("grant");
   property p_wake_bound;
      $rose(ceramic_main_clock_en_o) |-> cpu_halt_o ##[1:40] !cpu_halt_o;
   endproperty
   a_wake_bound: assert property (p_wake_bound) else $error("no run");
   property p_wake_len;
      armed && $fell(cpu_halt_o) |->
         wk_cnt >= RESTART_CYC - 1 && wk_cnt <= RESTART_CYC + 1;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("restart");
   c_top: cover property (irq_req_o && irq_level_o == 2'h3);
   c_wake: cover property (armed && $fell(cpu_halt_o));
   c_plain: cover property (push_o && push_bytes_o == 3'h4);
endmodule
bind irq_priority_and_standby_wake irq_wake_props #(
   .RESTART_CYC(RESTART_CYC)
) u_props (
   .mclk_i(mclk_i), .rst_i(rst_i), .irq_req_o(irq_req_o),
   .irq_vec_o(irq_vec_o), .irq_level_o(irq_level_o),
   .irq_ack_i(irq_ack_i), .irq_ret_i(irq_ret_i), .call_psw_i(call_psw_i),
   .call_plain_i(call_plain_i), .push_o(push_o),
   .push_bytes_o(push_bytes_o), .cpu_halt_o(cpu_halt_o),
   .periph_stop_o(periph_stop_o),
   .ceramic_main_clock_en_o(ceramic_main_clock_en_o),
   .internal_oscillator_clock_en_o(internal_oscillator_clock_en_o),
   .low_speed_crystal_clock_en_o(low_speed_crystal_clock_en_o));

/* File: tb/core_model.sv */
// processor core model: takes offered vectors, returns on request
// assumes registered grant outputs on mclk_i
`timescale 1ns/10ps
module core_model (
   // clock and reset
   input  wire        mclk_i,
   input  wire        rst_i,
   // arbiter side
   input  wire        req_i,
   input  wire [19:0] vec_i,
   input  wire [1:0]  lvl_i,
   output reg         ack_o,
   output reg         ret_o,
   // bench control
   input  wire        slow_i,
   input  wire        ret_req_i,
   output reg  [7:0]  cnt_o,
   output reg  [19:0] vec_o,
   output reg  [1:0]  lvl_o
);
   reg [1:0] dly;
   always @(posedge mclk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         ret_o <= 1'b0;
         dly   <= 2'h0;
         cnt_o <= 8'h00;
         vec_o <= 20'h00000;
         lvl_o <= 2'h0;
      end else begin
         ret_o <= ret_req_i;
         dly   <= 2'h0;
         if (ack_o) begin
            ack_o <= 1'b0;
            if (req_i) begin
               cnt_o <= cnt_o + 8'h01;
               vec_o <= vec_i;
               lvl_o <= lvl_i;
            end
         end else if (req_i) begin
            if (dly >= (slow_i ? 2'h3 : 2'h0))
               ack_o <= 1'b1;
            else
               dly <= dly + 2'h1;
         end
      end
   end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the interrupt arbiter and standby logic
// assumes core_model and a restart count of 3 cycles
`timescale 1ns/10ps
module testbench;
   reg         mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   reg  [3:0]  addr_i = 4'h0;
   reg  [15:0] wdata_i = 16'h0000;
   reg  [49:0] periph_irq_i = 50'h0;
   reg  [7:0]  ext_irq_pin_i = 8'h00;
   reg  [5:0]  port0_pin_i = 6'h00;
   reg         reset_pin_n_i = 1'b1, call_psw_i = 1'b0, call_plain_i = 1'b0;
   reg         slow = 1'b0, ret_req = 1'b0, s;
   wire [15:0] rdata_o;
   wire        irq_req_o, irq_ack_i, irq_ret_i, push_o;
   wire        cpu_halt_o, periph_stop_o, cer, ino, xtl;
   wire [19:0] irq_vec_o, t_vec;
   wire [1:0]  irq_level_o, t_lvl;
   wire [2:0]  push_bytes_o;
   wire [7:0]  t_cnt;
   wire [4:0]  sby = {cpu_halt_o, periph_stop_o, cer, ino, xtl};
   integer     n_fail = 0, compares = 0, i, k;
   localparam [95:0] SRC = {6'd49, 6'd48, 6'd40, 6'd37, 6'd33, 6'd32, 6'd28,
      6'd26, 6'd23, 6'd17, 6'd11, 6'd7, 6'd5, 6'd3, 6'd1, 6'd0};
   localparam [127:0] VLO = 128'h3C3C3C38_34343028_24201C18_18080400;
   irq_priority_and_standby_wake #(.RESTART_CYC(3)) u_dut (
      .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .periph_irq_i(periph_irq_i), .ext_irq_pin_i(ext_irq_pin_i),
      .port0_pin_i(port0_pin_i), .reset_pin_n_i(reset_pin_n_i),
      .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o),
      .irq_level_o(irq_level_o), .irq_ack_i(irq_ack_i),
      .irq_ret_i(irq_ret_i), .call_psw_i(call_psw_i),
      .call_plain_i(call_plain_i), .push_o(push_o),
      .push_bytes_o(push_bytes_o), .cpu_halt_o(cpu_halt_o),
      .periph_stop_o(periph_stop_o), .ceramic_main_clock_en_o(cer),
      .internal_oscillator_clock_en_o(ino),
      .low_speed_crystal_clock_en_o(xtl));
   core_model u_core (
      .mclk_i(mclk_i), .rst_i(rst_i), .req_i(irq_req_o), .vec_i(irq_vec_o),
      .lvl_i(irq_level_o), .ack_o(irq_ack_i), .ret_o(irq_ret_i),
      .slow_i(slow), .ret_req_i(ret_req), .cnt_o(t_cnt), .vec_o(t_vec),
      .lvl_o(t_lvl));
   always #5 mclk_i = ~mclk_i;
   task chk(input [19:0] got, input [19:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task conclude;
      begin
         $display("compares %0d n_fail %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge mclk_i);
         #1;
      end
   endtask
   task hang(input integer n);
      if (n >= 80) begin
         n_fail = n_fail + 1;
         conclude;
      end
   endtask
   task reg_wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge mclk_i);
         wr_i <= 1'b0;
         #1;
      end
   endtask
   task reg_rd(input [3:0] a, input [15:0] e);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge mclk_i);
         rd_i <= 1'b0;
         #1 chk(20'(rdata_o), 20'(e));
      end
   endtask
   task take(input [19:0] v, input [1:0] l);
      reg [7:0] c;
      begin
         c = t_cnt;
         for (k = 0; t_cnt === c && k < 80; k = k + 1)
            tick(1);
         hang(k);
         chk(t_vec, v);
         chk(20'(t_lvl), 20'(l));
      end
   endtask
   task wake;
      begin
         for (k = 0; cpu_halt_o !== 1'b0 && k < 80; k = k + 1)
            tick(1);
         hang(k);
         chk(20'(sby[4:1]), 20'h3);
      end
   endtask
   task do_ret;
      begin
         @(posedge mclk_i) ret_req <= 1'b1;
         @(posedge mclk_i) ret_req <= 1'b0;
         tick(2);
      end
   endtask
   initial begin
      repeat (100000) @(posedge mclk_i);
      n_fail = n_fail + 1;
      conclude;
   end
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      tick(1);
      chk(irq_vec_o, 20'h08000);
      chk(20'(sby), 20'h06);
      reg_rd(4'hF, 16'h0000);
      reg_rd(4'h8, 16'h0100);
      reg_wr(4'h0, 16'h5555);
      reg_wr(4'h1, 16'h0555);
      reg_rd(4'h1, 16'h0555);
      for (i = 0; i < 16; i = i + 1) begin
         slow <= i[0];
         @(posedge mclk_i) periph_irq_i[SRC[6*i +: 6]] <= 1'b1;
         take({12'h080, VLO[8*i +: 8]}, 2'h1);
         @(posedge mclk_i) periph_irq_i[SRC[6*i +: 6]] <= 1'b0;
         do_ret;
      end
      reg_wr(4'h4, 16'h003F);
      for (i = 0; i < 6; i = i + 1) begin
         @(posedge mclk_i) port0_pin_i[i] <= 1'b1;
         take(20'h0803C, 2'h1);
         @(posedge mclk_i) port0_pin_i[i] <= 1'b0;
         do_ret;
      end
      $display("vector table done");
      for (i = 1; i < 6; i = i + 1) begin
         s = (i == 2 || i == 4);
         @(posedge mclk_i) ext_irq_pin_i[0] <= s;
         tick(4);
         reg_wr(4'h2, i[15:0]);
         reg_wr(4'h5, 16'h00FF);
         tick(6);
         chk(20'(irq_req_o), 20'h0);
         @(posedge mclk_i) ext_irq_pin_i[0] <= ~s;
         take(20'h0800C, 2'h1);
         reg_rd(4'h5, {15'h0000, i > 2});
         reg_wr(4'h2, 16'h0000);
         reg_wr(4'h5, 16'h00FF);
         do_ret;
      end
      $display("pin modes done");
      reg_wr(4'h0, 16'h5569);
      reg_wr(4'h1, 16'h0D55);
      @(posedge mclk_i) periph_irq_i <= 50'h0B;
      take(20'h08004, 2'h2);
      @(posedge mclk_i) periph_irq_i[1] <= 1'b0;
      tick(8);
      chk(20'(irq_req_o), 20'h0);
      reg_rd(4'h7, 16'h0005);
      reg_rd(4'h8, 16'h0108);
      @(posedge mclk_i) periph_irq_i[48] <= 1'b1;
      take(20'h0803C, 2'h3);
      @(posedge mclk_i) periph_irq_i[48] <= 1'b0;
      do_ret;
      tick(8);
      chk(20'(irq_req_o), 20'h0);
      do_ret;
      take(20'h08008, 2'h2);
      @(posedge mclk_i) periph_irq_i[3] <= 1'b0;
      do_ret;
      take(20'h08000, 2'h1);
      @(posedge mclk_i) periph_irq_i[0] <= 1'b0;
      do_ret;
      @(posedge mclk_i) call_psw_i <= 1'b1;
      @(posedge mclk_i) call_psw_i <= 1'b0;
      #1 chk({push_o, push_bytes_o}, 20'hE);
      @(posedge mclk_i) call_plain_i <= 1'b1;
      @(posedge mclk_i) call_plain_i <= 1'b0;
      #1 chk({push_o, push_bytes_o}, 20'hC);
      $display("priority done");
      reg_wr(4'h6, 16'h0001);
      chk(20'(sby), 20'h16);
      reg_rd(4'h8, 16'h0200);
      @(posedge mclk_i) periph_irq_i[0] <= 1'b1;
      take(20'h08000, 2'h1);
      chk(20'(sby), 20'h06);
      @(posedge mclk_i) periph_irq_i[0] <= 1'b0;
      do_ret;
      reg_wr(4'h2, 16'h0200);
      reg_wr(4'h6, 16'h0012);
      chk(20'(sby), 20'h18);
      @(posedge mclk_i) periph_irq_i[0] <= 1'b1;
      @(posedge mclk_i) ext_irq_pin_i[3] <= 1'b1;
      tick(12);
      chk(20'(sby), 20'h18);
      @(posedge mclk_i) periph_irq_i[0] <= 1'b0;
      @(posedge mclk_i) ext_irq_pin_i[3] <= 1'b0;
      tick(4);
      @(posedge mclk_i) periph_irq_i[40] <= 1'b1;
      wake;
      take(20'h0803C, 2'h3);
      @(posedge mclk_i) periph_irq_i[40] <= 1'b0;
      do_ret;
      reg_wr(4'h6, 16'h0010);
      reg_wr(4'h6, 16'h0013);
      chk(20'(sby), 20'h19);
      reg_rd(4'h8, 16'h0800);
      @(posedge mclk_i) periph_irq_i[49] <= 1'b1;
      tick(12);
      chk(20'(sby), 20'h19);
      @(posedge mclk_i) periph_irq_i[49] <= 1'b0;
      @(posedge mclk_i) periph_irq_i[1] <= 1'b1;
      wake;
      take(20'h08004, 2'h2);
      @(posedge mclk_i) periph_irq_i[1] <= 1'b0;
      do_ret;
      reg_wr(4'h6, 16'h0002);
      chk(20'(sby), 20'h18);
      @(posedge mclk_i) reset_pin_n_i <= 1'b0;
      wake;
      @(posedge mclk_i) reset_pin_n_i <= 1'b1;
      $display("standby done");
      conclude;
   end
endmodule
